// File: logger_pkg.sv
// Shared constants and carrier types for the event and interval logger.
// Assumes a 200 MHz clock and a 64-bit word-wide non-volatile store.
`default_nettype none

package logger_pkg;
    // Store geometry
    localparam int EV_DEPTH = 1024;
    localparam int IV_DAYS = 120;
    localparam int IV_PER_DAY = 24;
    localparam int IV_DEPTH = IV_DAYS * IV_PER_DAY;
    localparam int AGE_W = 12;
    // Word addresses in the non-volatile store
    localparam logic [11:0] EV_BASE = 12'h000;
    localparam logic [11:0] IV_BASE = 12'h400;
    localparam logic [11:0] HDR_ADDR = 12'hf40;
    localparam logic [11:0] DYN_ADDR = 12'hf41;
    // Timing
    localparam int INTERVAL_SEC = 3600;
    localparam int CLK_PERIOD_NS = 5;
    localparam int FLASH_MS = 100;
    localparam int FLASH_CYC = FLASH_MS * 1000000 / CLK_PERIOD_NS;
    // Record kinds and header marker
    localparam logic [3:0] KIND_EVENT = 4'h1;
    localparam logic [3:0] KIND_INTERVAL = 4'h2;
    localparam logic [3:0] KIND_PDOWN = 4'h3;
    localparam logic [3:0] KIND_PUP = 4'h4;
    localparam logic [7:0] HDR_MARK = 8'ha5;
    // Status word field positions
    localparam int BF_BIT = 10;
    localparam int LOWBAT_BIT = 11;

    // One stored record, one store word
    typedef struct packed {
        logic [3:0] kind;
        logic [11:0] info;
        logic [15:0] banks;
        logic [31:0] stamp;
    } record_t;

    // Pointer state saved at power-down
    typedef struct packed {
        logic [7:0] mark;
        logic evFull;
        logic [9:0] evHead;
        logic ivFull;
        logic [11:0] ivHead;
        logic [31:0] stamp;
    } header_t;

    // Off-load request
    typedef struct packed {
        logic isQuery;
        logic isInterval;
        logic [11:0] age;
        logic [31:0] when;
    } request_t;
endpackage : logger_pkg

`default_nettype wire

// File: ring_index.sv
// Circular store index: head, wrap, full flag and age to slot mapping.
// Assumes the owner advances it only after a slot write is accepted.
`default_nettype none

module ring_index #(
    parameter int DEPTH = 1024,
    parameter int AW = $clog2(DEPTH)
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Control
    input wire logic advance,
    input wire logic load,
    input wire logic [AW-1:0] loadHead,
    input wire logic loadFull,
    input wire logic [11:0] age,
    // State
    output logic [AW-1:0] head,
    output logic full,
    output logic [AW-1:0] succHead,
    output logic succFull,
    output logic [AW-1:0] ageIdx,
    output logic ageOk
);
    logic [AW-1:0] head_r, head_nxt; // Next slot to write
    logic full_r, full_nxt; // Set once the ring has wrapped

    if (DEPTH < 2 || DEPTH > 4096) begin : g_chk
        $error("ring_index: DEPTH out of range");
    end

    // Successor and age arithmetic
    always_comb begin
        int back;
        back = int'(head_r) - 1 - int'(age);
        if (back < 0) begin
            back = back + DEPTH;
        end
        ageIdx = AW'(back);
        ageOk = full_r ? (int'(age) < DEPTH) : (int'(age) < int'(head_r));
        // Oldest slot is reused once full
        succFull = full_r || (int'(head_r) == DEPTH - 1);
        succHead = (int'(head_r) == DEPTH - 1) ? '0 : AW'(head_r + 1'b1);
        head_nxt = head_r;
        full_nxt = full_r;
        if (load) begin
            head_nxt = loadHead;
            full_nxt = loadFull;
        end else if (advance) begin
            head_nxt = succHead;
            full_nxt = succFull;
        end
    end

    // Index registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            head_r <= '0;
            full_r <= 1'b0;
        end else begin
            head_r <= head_nxt;
            full_r <= full_nxt;
        end
    end

    assign head = head_r;
    assign full = full_r;

    chk_ring_wrap: assert property (@(posedge clock) disable iff (!rst_b)
        (advance && !load && int'(head_r) == DEPTH - 1) |=> (head_r == '0 && full_r))
        else $error("ring did not wrap to the oldest slot");
endmodule : ring_index

`default_nettype wire

// File: event_interval_logger.sv
// Event and interval logger with power-fail save, writing a word store.
// Assumes status, calendar and requests share the clock; pins are async.
// Functional notes
// - Log each status change with calendar stamp
// - Keep the newest 1024 events
// - Log parameters and banks every interval
// - Interval store fixed at 120 hourly days
// - Full interval store overwrites oldest record
// - Reader off-loads records on request
// - Answer fault and bank status at time
// - Power warning saves dynamics and down record
// - Power return writes matching up record
// - Backlight off on warning, flash after save
// - Save keeps pointers and counters intact
// - Battery fault raises status, stops logging
// - Low battery indicated; faults appear in log
`default_nettype none

module event_interval_logger
    import logger_pkg::*;
#(
    parameter int FLASH_CYCLES = FLASH_CYC,
    parameter int INTERVAL_SECONDS = INTERVAL_SEC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Operating status
    input wire logic [9:0] faultFlags,
    input wire logic [15:0] bankState,
    input wire logic [11:0] paramWord,
    input wire logic [63:0] dynData,
    // Calendar
    input wire logic [31:0] rtcNow,
    input wire logic secondTick,
    // Supply and battery pins
    input wire logic pfWarnPin,
    input wire logic battFaultPin,
    input wire logic battLowPin,
    // Off-load requests from the reader side
    input wire logic reqValid,
    input wire request_t reqIn,
    output logic reqReady,
    output logic ansValid,
    output record_t ansRec,
    output logic ansHit,
    // Non-volatile store
    output logic nvmReq,
    output logic nvmWe,
    output logic [11:0] nvmAddr,
    output logic [63:0] nvmWdata,
    input wire logic nvmAck,
    input wire logic [63:0] nvmRdata,
    // Indicators
    output logic backlightOn,
    output logic backupCellFaultStatus,
    output logic lowBattery,
    output logic loggingStopped
);
    localparam int FW = $clog2(FLASH_CYCLES + 1);
    localparam int SW = $clog2(INTERVAL_SECONDS + 1);

    if (FLASH_CYCLES < 1 || INTERVAL_SECONDS < 1) begin : g_chk
        $error("event_interval_logger: counts must be at least one");
    end

    typedef enum logic [3:0] {
        S_RESTORE, S_IDLE, S_LOG_EVENT, S_LOG_IV, S_FETCH, S_READ,
        S_PD_EVENT, S_PD_HDR, S_PD_DYN, S_FLASH, S_HALT
    } state_t;

    // Pin synchronisers, first stage read only by the second
    logic [2:0] pinMeta_r, pinSync_r;
    logic pfWarnS, battFaultS;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pinMeta_r <= 3'h0;
            pinSync_r <= 3'h0;
        end else begin
            pinMeta_r <= {battLowPin, battFaultPin, pfWarnPin};
            pinSync_r <= pinMeta_r;
        end
    end
    assign pfWarnS = pinSync_r[0];
    assign battFaultS = pinSync_r[1];

    // Controller state
    state_t state_r, state_nxt;
    logic [11:0] addr_r, addr_nxt; // Store address of the access
    logic we_r, we_nxt; // Access is a write
    logic [63:0] wdata_r, wdata_nxt; // Write word
    logic [27:0] lastStat_r, lastStat_nxt; // Status last logged
    logic puPend_r, puPend_nxt; // Power-up record still owed
    logic ivDue_r, ivDue_nxt; // Interval record owed
    logic [SW-1:0] secCnt_r, secCnt_nxt; // Seconds into interval
    logic [FW-1:0] flash_r, flash_nxt; // Backlight flash countdown
    logic backlight_r, backlight_nxt;
    request_t req_r, req_nxt; // Request being served
    logic [11:0] scan_r, scan_nxt; // Age being fetched
    logic ansValid_r, ansValid_nxt;
    logic ansHit_r, ansHit_nxt;
    record_t ansRec_r, ansRec_nxt;

    // Ring control
    logic evAdv, ivAdv, ptrLoad;
    logic [9:0] evHead, evSucc, evIdx;
    logic [11:0] ivHead, ivIdx;
    logic evFull, evSuccFull, evOk, ivFull, ivOk;

    logic [11:0] curInfo; // Fault word including battery flags
    logic [27:0] curStat;
    logic logAllowed, evChange, reqTake;
    record_t rdRec, wrRec;
    header_t rdHdr, pdHdr;

    // Battery flags go into the logged status word
    assign curInfo = {pinSync_r[2], battFaultS, faultFlags};
    assign curStat = {curInfo, bankState};
    // Logging halts once a battery fault itself has been logged
    assign logAllowed = !(battFaultS && lastStat_r[16 + BF_BIT]);
    assign evChange = logAllowed && (curStat != lastStat_r);
    assign rdRec = record_t'(nvmRdata);
    assign rdHdr = header_t'(nvmRdata);
    assign wrRec = record_t'(wdata_r);
    assign pdHdr = '{mark: HDR_MARK, evFull: evSuccFull, evHead: evSucc,
                     ivFull: ivFull, ivHead: ivHead, stamp: rtcNow};
    assign reqReady = (state_r == S_IDLE) && !pfWarnS && !puPend_r && !evChange
                      && !(logAllowed && ivDue_r);
    assign reqTake = reqReady && reqValid;

    ring_index #(.DEPTH(EV_DEPTH)) evRing (
        .clock(clock), .rst_b(rst_b), .advance(evAdv), .load(ptrLoad),
        .loadHead(rdHdr.evHead), .loadFull(rdHdr.evFull), .age(scan_r),
        .head(evHead), .full(evFull), .succHead(evSucc), .succFull(evSuccFull),
        .ageIdx(evIdx), .ageOk(evOk)
    );

    // Interval store sized for hourly records over the fixed span
    ring_index #(.DEPTH(IV_DEPTH)) ivRing (
        .clock(clock), .rst_b(rst_b), .advance(ivAdv), .load(ptrLoad),
        .loadHead(rdHdr.ivHead), .loadFull(rdHdr.ivFull), .age(scan_r),
        .head(ivHead), .full(ivFull), .succHead(), .succFull(),
        .ageIdx(ivIdx), .ageOk(ivOk)
    );

    // Next-state logic for the whole controller
    always_comb begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        we_nxt = we_r;
        wdata_nxt = wdata_r;
        lastStat_nxt = lastStat_r;
        puPend_nxt = puPend_r;
        ivDue_nxt = ivDue_r;
        secCnt_nxt = secCnt_r;
        flash_nxt = flash_r;
        backlight_nxt = backlight_r;
        req_nxt = req_r;
        scan_nxt = scan_r;
        ansValid_nxt = 1'b0;
        ansHit_nxt = ansHit_r;
        ansRec_nxt = ansRec_r;
        evAdv = 1'b0;
        ivAdv = 1'b0;
        ptrLoad = 1'b0;
        // Interval timer; a due flag raised now beats the clear below
        if (secondTick) begin
            secCnt_nxt = (int'(secCnt_r) == INTERVAL_SECONDS - 1) ? '0 : SW'(secCnt_r + 1'b1);
        end
        case (state_r)
            S_RESTORE: begin
                // Pointers survive only if a valid header was saved
                if (nvmAck) begin
                    ptrLoad = (rdHdr.mark == HDR_MARK);
                    state_nxt = S_IDLE;
                end
            end
            S_IDLE: begin
                if (pfWarnS) begin
                    backlight_nxt = 1'b0;
                    addr_nxt = EV_BASE + 12'(evHead);
                    we_nxt = 1'b1;
                    wdata_nxt = {KIND_PDOWN, curInfo, bankState, rtcNow};
                    state_nxt = S_PD_EVENT;
                end else if (puPend_r || evChange) begin
                    addr_nxt = EV_BASE + 12'(evHead);
                    we_nxt = 1'b1;
                    wdata_nxt = {(puPend_r ? KIND_PUP : KIND_EVENT), curInfo,
                                 bankState, rtcNow};
                    state_nxt = S_LOG_EVENT;
                end else if (logAllowed && ivDue_r) begin
                    addr_nxt = IV_BASE + ivHead;
                    we_nxt = 1'b1;
                    wdata_nxt = {KIND_INTERVAL, paramWord, bankState, rtcNow};
                    state_nxt = S_LOG_IV;
                end else if (reqTake) begin
                    req_nxt = reqIn;
                    req_nxt.isInterval = reqIn.isInterval && !reqIn.isQuery;
                    scan_nxt = reqIn.isQuery ? 12'h000 : reqIn.age;
                    state_nxt = S_FETCH;
                end
            end
            S_LOG_EVENT: begin
                if (nvmAck) begin
                    evAdv = 1'b1;
                    puPend_nxt = 1'b0;
                    lastStat_nxt = {wrRec.info, wrRec.banks};
                    state_nxt = S_IDLE;
                end
            end
            S_LOG_IV: begin
                if (nvmAck) begin
                    ivAdv = 1'b1;
                    ivDue_nxt = 1'b0;
                    state_nxt = S_IDLE;
                end
            end
            S_FETCH: begin
                // Ages past the stored count answer as a miss
                if (req_r.isInterval ? ivOk : evOk) begin
                    addr_nxt = req_r.isInterval ? (IV_BASE + ivIdx) : (EV_BASE + 12'(evIdx));
                    we_nxt = 1'b0;
                    state_nxt = S_READ;
                end else begin
                    ansValid_nxt = 1'b1;
                    ansHit_nxt = 1'b0;
                    ansRec_nxt = '0;
                    state_nxt = S_IDLE;
                end
            end
            S_READ: begin
                if (nvmAck) begin
                    // Walk back from newest to the first record at or before the time
                    if (!req_r.isQuery || rdRec.stamp <= req_r.when) begin
                        ansValid_nxt = 1'b1;
                        ansHit_nxt = 1'b1;
                        ansRec_nxt = rdRec;
                        state_nxt = S_IDLE;
                    end else begin
                        scan_nxt = scan_r + 12'h001;
                        state_nxt = S_FETCH;
                    end
                end
            end
            S_PD_EVENT: begin
                if (nvmAck) begin
                    evAdv = 1'b1;
                    addr_nxt = HDR_ADDR;
                    wdata_nxt = pdHdr;
                    state_nxt = S_PD_HDR;
                end
            end
            S_PD_HDR: begin
                if (nvmAck) begin
                    addr_nxt = DYN_ADDR;
                    wdata_nxt = dynData;
                    state_nxt = S_PD_DYN;
                end
            end
            S_PD_DYN: begin
                if (nvmAck) begin
                    backlight_nxt = 1'b1;
                    flash_nxt = FW'(FLASH_CYCLES - 1);
                    state_nxt = S_FLASH;
                end
            end
            S_FLASH: begin
                if (flash_r == '0) begin
                    backlight_nxt = 1'b0;
                    state_nxt = S_HALT;
                end else begin
                    flash_nxt = flash_r - 1'b1;
                end
            end
            S_HALT: begin
                // Supply came back without a reset: owe a power-up record
                if (!pfWarnS) begin
                    backlight_nxt = 1'b1;
                    puPend_nxt = 1'b1;
                    state_nxt = S_IDLE;
                end
            end
            default: state_nxt = S_IDLE;
        endcase
        if (secondTick && int'(secCnt_r) == INTERVAL_SECONDS - 1) begin
            ivDue_nxt = 1'b1;
        end
    end

    // Controller registers; restore read of the header starts at reset
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= S_RESTORE;
            addr_r <= HDR_ADDR;
            we_r <= 1'b0;
            wdata_r <= 64'h0;
            lastStat_r <= 28'h0;
            puPend_r <= 1'b1;
            ivDue_r <= 1'b0;
            secCnt_r <= '0;
            flash_r <= '0;
            backlight_r <= 1'b1;
            req_r <= '0;
            scan_r <= 12'h000;
            ansValid_r <= 1'b0;
            ansHit_r <= 1'b0;
            ansRec_r <= '0;
        end else begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            we_r <= we_nxt;
            wdata_r <= wdata_nxt;
            lastStat_r <= lastStat_nxt;
            puPend_r <= puPend_nxt;
            ivDue_r <= ivDue_nxt;
            secCnt_r <= secCnt_nxt;
            flash_r <= flash_nxt;
            backlight_r <= backlight_nxt;
            req_r <= req_nxt;
            scan_r <= scan_nxt;
            ansValid_r <= ansValid_nxt;
            ansHit_r <= ansHit_nxt;
            ansRec_r <= ansRec_nxt;
        end
    end

    // Outputs
    assign nvmReq = (state_r == S_RESTORE) || (state_r == S_LOG_EVENT) ||
                    (state_r == S_LOG_IV) || (state_r == S_READ) ||
                    (state_r == S_PD_EVENT) || (state_r == S_PD_HDR) ||
                    (state_r == S_PD_DYN);
    assign nvmWe = we_r;
    assign nvmAddr = addr_r;
    assign nvmWdata = wdata_r;
    assign ansValid = ansValid_r;
    assign ansHit = ansHit_r;
    assign ansRec = ansRec_r;
    assign backlightOn = backlight_r;
    assign backupCellFaultStatus = battFaultS;
    assign lowBattery = pinSync_r[2];
    assign loggingStopped = !logAllowed;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence pdSaved;
        state_r == S_PD_DYN && nvmAck;
    endsequence

    sequence flashHeld;
        backlight_r [*2];
    endsequence

    chk_event_taken: assert property (
        (state_r == S_IDLE && !pfWarnS && !puPend_r && evChange) |=> state_r == S_LOG_EVENT)
        else $error("status change not logged");
    chk_event_stamp: assert property (
        $rose(state_r == S_LOG_EVENT) |-> wrRec.stamp == $past(rtcNow))
        else $error("event stamp is not the calendar time");
    chk_event_slot: assert property (
        state_r == S_LOG_EVENT |-> nvmAddr == EV_BASE + 12'(evHead))
        else $error("event written outside the newest slot");
    chk_interval_due: assert property (
        (secondTick && int'(secCnt_r) == INTERVAL_SECONDS - 1) |=> ivDue_r)
        else $error("interval end not flagged");
    chk_powerdown_start: assert property (
        (state_r == S_IDLE && pfWarnS) |=> (state_r == S_PD_EVENT && !backlight_r
        && wrRec.kind == KIND_PDOWN))
        else $error("power warning did not start the save");
    chk_header_save: assert property (
        state_r == S_PD_HDR |-> (nvmWe && nvmAddr == HDR_ADDR && wdata_r[63:56] == HDR_MARK))
        else $error("pointer header not saved");
    chk_flash_once: assert property (
        pdSaved |=> flashHeld)
        else $error("backlight did not flash after save");
    chk_powerup_kind: assert property (
        (state_r == S_LOG_EVENT && puPend_r) |-> wrRec.kind == KIND_PUP)
        else $error("power-up record missing");
    chk_battery_stop: assert property (
        (state_r == S_IDLE && battFaultS && lastStat_r[16 + BF_BIT] && !pfWarnS
        && !puPend_r) |=> state_r != S_LOG_IV && state_r != S_LOG_EVENT)
        else $error("logging continued under battery fault");
    chk_query_time: assert property (
        (ansValid_r && ansHit_r && req_r.isQuery) |-> ansRec_r.stamp <= req_r.when)
        else $error("query answer later than asked time");
endmodule : event_interval_logger

`default_nettype wire

// File: nvm_model.sv
// Word store model that answers the logger's store port.
// Assumes one access at a time; each is acked after ackDelay waits.
`default_nettype none

module nvm_model (
    // Clock
    input wire logic clock,
    // Store port
    input wire logic nvmReq,
    input wire logic nvmWe,
    input wire logic [11:0] nvmAddr,
    input wire logic [63:0] nvmWdata,
    output logic nvmAck,
    output logic [63:0] nvmRdata,
    // Answer delay in cycles
    input wire logic [3:0] ackDelay
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [63:0] mem [4096] = '{default: 64'h0}; // Erased store, so no header marker
    int waitCnt = 0; // Cycles waited on the open access
    // Read data toggles between acks so a stale sample cannot match
    always @(posedge clock) begin
        if (nvmReq && !nvmAck && waitCnt >= ackDelay) begin
            waitCnt <= 0;
            nvmAck <= 1'b1;
            // Contents survive any reset of the logger
            if (nvmWe) mem[nvmAddr] <= nvmWdata;
            nvmRdata <= nvmWe ? ~nvmRdata : mem[nvmAddr];
        end else begin
            nvmAck <= 1'b0;
            nvmRdata <= ~nvmRdata;
            if (nvmReq && !nvmAck) waitCnt <= waitCnt + 1;
        end
    end
endmodule : nvm_model

`default_nettype wire

// File: tb_event_interval_logger.sv
// Self-checking bench for the event and interval logger.
// Assumes the store model answers every access; short flash and interval.
`default_nettype none

module tb_event_interval_logger
    import logger_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FLASH = 8; // Short flash keeps the run brief
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [9:0] faultFlags = 10'h000;
    logic [15:0] bankState = 16'h0000;
    logic [11:0] paramWord = 12'h5a3;
    logic [63:0] dynData = 64'h0123456789abcdef;
    logic [31:0] rtcNow = 32'h00001000;
    logic secondTick = 1'b0, pfWarnPin = 1'b0, battFaultPin = 1'b0, battLowPin = 1'b0;
    logic reqValid = 1'b0;
    request_t reqIn = '0;
    logic reqReady, ansValid, ansHit, nvmReq, nvmWe, nvmAck;
    record_t ansRec;
    logic [11:0] nvmAddr;
    logic [63:0] nvmWdata, nvmRdata;
    logic backlightOn, backupCellFaultStatus, lowBattery, loggingStopped;
    logic [3:0] ackDelay = 4'h3; // Slow store unless a test speeds it up
    header_t hdr;
    int failures = 0;
    int checkCount = 0;

    event_interval_logger #(.FLASH_CYCLES(FLASH), .INTERVAL_SECONDS(3)) DUT (
        .clock(clock), .rst_b(rst_b), .faultFlags(faultFlags), .bankState(bankState),
        .paramWord(paramWord), .dynData(dynData), .rtcNow(rtcNow), .secondTick(secondTick),
        .pfWarnPin(pfWarnPin), .battFaultPin(battFaultPin), .battLowPin(battLowPin),
        .reqValid(reqValid), .reqIn(reqIn), .reqReady(reqReady), .ansValid(ansValid),
        .ansRec(ansRec), .ansHit(ansHit), .nvmReq(nvmReq), .nvmWe(nvmWe),
        .nvmAddr(nvmAddr), .nvmWdata(nvmWdata), .nvmAck(nvmAck), .nvmRdata(nvmRdata),
        .backlightOn(backlightOn), .backupCellFaultStatus(backupCellFaultStatus),
        .lowBattery(lowBattery), .loggingStopped(loggingStopped));
    nvm_model nvm (.clock(clock), .nvmReq(nvmReq), .nvmWe(nvmWe), .nvmAddr(nvmAddr),
        .nvmWdata(nvmWdata), .nvmAck(nvmAck), .nvmRdata(nvmRdata), .ackDelay(ackDelay));

    // Clock, 5 ns period
    initial begin
        forever #2.5 clock = ~clock;
    end
    // Compare one value and count it
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        checkCount++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Wait until the block is idle with nothing pending
    task automatic settle();
        int i;
        repeat (4) @(negedge clock);
        for (i = 0; i < 400 && reqReady !== 1'b1; i++) @(negedge clock);
    endtask : settle
    // One off-load request, held over the accepting edge only
    task automatic ask(input logic q, iv, input logic [11:0] age, input logic [31:0] when);
        int i;
        settle();
        reqIn = {q, iv, age, when};
        reqValid = 1'b1;
        @(negedge clock);
        reqValid = 1'b0;
        for (i = 0; i < 400 && ansValid !== 1'b1; i++) @(negedge clock);
        check("answer pulse", 64'h1, {63'h0, ansValid});
    endtask : ask
    task automatic t_powerup();
        settle();
        check("power-up kind", 64'h4, nvm.mem[0][63:60]);
        check("power-up stamp", 64'h1000, nvm.mem[0][31:0]);
        $display("t_powerup done");
    endtask : t_powerup
    task automatic t_event();
        faultFlags = 10'h005;
        bankState = 16'h00f0;
        rtcNow = 32'h00002000;
        ask(1'b0, 1'b0, 12'h000, 32'h0);
        check("event record", {4'h1, 12'h005, 16'h00f0, 32'h2000}, ansRec);
        $display("t_event done");
    endtask : t_event
    task automatic t_interval();
        rtcNow = 32'h00003000;
        repeat (3) begin
            @(negedge clock);
            secondTick = 1'b1;
            @(negedge clock);
            secondTick = 1'b0;
        end
        ask(1'b0, 1'b1, 12'h000, 32'h0);
        check("interval record", {4'h2, 12'h5a3, 16'h00f0, 32'h3000}, ansRec);
        $display("t_interval done");
    endtask : t_interval
    task automatic t_query();
        ask(1'b1, 1'b0, 12'h000, 32'h00002fff);
        check("query banks", 64'h00f0, ansRec.banks);
        check("query hit", 64'h1, ansHit);
        ask(1'b1, 1'b0, 12'h000, 32'h00000fff);
        check("query miss", 64'h0, ansHit);
        $display("t_query done");
    endtask : t_query
    task automatic t_battery();
        battLowPin = 1'b1;
        ask(1'b0, 1'b0, 12'h000, 32'h0);
        check("low battery", 64'h1, lowBattery);
        check("low in log", 64'h1, ansRec.info[11]);
        battFaultPin = 1'b1;
        ask(1'b0, 1'b0, 12'h000, 32'h0);
        check("fault status", 64'h1, backupCellFaultStatus);
        check("fault in log", 64'h1, ansRec.info[10]);
        check("logging stopped", 64'h1, loggingStopped);
        bankState = 16'h0ff0;
        ask(1'b0, 1'b0, 12'h000, 32'h0);
        check("no new event", 64'h00f0, ansRec.banks);
        battLowPin = 1'b0;
        battFaultPin = 1'b0;
        settle();
        check("logging resumed", 64'h0, loggingStopped);
        $display("t_battery done");
    endtask : t_battery
    task automatic t_wrap();
        ackDelay = 4'h0;
        for (int k = 1; k <= 1024; k++) begin
            bankState = k[15:0];
            settle();
        end
        ask(1'b0, 1'b0, 12'd1023, 32'h0);
        check("oldest kept", 64'h1, ansRec.banks);
        ask(1'b0, 1'b0, 12'd1024, 32'h0);
        check("beyond depth", 64'h0, ansHit);
        ackDelay = 4'h3;
        $display("t_wrap done");
    endtask : t_wrap
    task automatic t_powerfail();
        int n;
        pfWarnPin = 1'b1;
        for (n = 0; n < 20 && backlightOn !== 1'b0; n++) @(negedge clock);
        check("backlight off", 64'h0, backlightOn);
        for (n = 0; n < 300 && backlightOn !== 1'b1; n++) @(negedge clock);
        for (n = 0; n < 100 && backlightOn === 1'b1; n++) @(negedge clock);
        check("flash cycles", FLASH, n);
        hdr = nvm.mem[HDR_ADDR];
        check("dyn saved", dynData, nvm.mem[DYN_ADDR]);
        check("header mark", 64'ha5, hdr.mark);
        check("header stamp", rtcNow, hdr.stamp);
        check("down kind", 64'h3, nvm.mem[{2'b00, hdr.evHead - 10'h001}][63:60]);
        // Supply returns through a reset; pointers come back from the header
        rst_b = 1'b0;
        pfWarnPin = 1'b0;
        repeat (3) @(negedge clock);
        rst_b = 1'b1;
        settle();
        check("up after save", 64'h4, nvm.mem[{2'b00, hdr.evHead}][63:60]);
        ask(1'b0, 1'b0, 12'h001, 32'h0);
        check("down kept", 64'h3, ansRec.kind);
        $display("t_powerfail done");
    endtask : t_powerfail
    // Verdict and end of run
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checkCount, failures);
        if (failures == 0 && checkCount > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    // Watchdog, well beyond the expected run length
    initial begin
        #250000;
        failures++;
        end_sim();
    end
    // Main sequence
    initial begin
        repeat (3) @(negedge clock);
        rst_b = 1'b1;
        t_powerup();
        t_event();
        t_interval();
        t_query();
        t_battery();
        t_wrap();
        t_powerfail();
        end_sim();
    end
endmodule : tb_event_interval_logger

`default_nettype wire
